//--- rtl/async_serial_receiver_channel.sv
// Asynchronous start-stop receive channel with Wishbone register access
//
// What this block does
// - Odd channel receives; both mode registers exist.
// - Framing, parity, overrun flags; separate error interrupt.
// - Seven or eight data bits selectable.
// - Fastest rate is clock over two, at divider zero.
// - Level bit optionally inverts received line.
// - Parity none, unchecked, even or odd.
// - Direction bit: MSB or LSB first.
// - Enable bit gates the error interrupt.
// - Clock-select bit picks one prescaler output.
// - Data register: divider high, character low.
// - Bit time is two times divider-plus-one.
`default_nettype none
module async_serial_receiver_channel (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Serial line and interrupts
   input  wire logic        serial_rx_pin_i,
   output logic             rx_done_irq_o,
   output logic             rx_error_irq_o
);
   typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP} rx_state_e;

   ////////////////////////////////////////////////////////////////
   // Registers and state
   logic [15:0] rx_mode_ff, pair_mode_ff, setup_ff, div_ff;
   logic [7:0]  presc_ff;
   logic        start_ff, ack_ff, ovf_ff, pef_ff, fef_ff, done_ff, err_ff;
   logic [31:0] rdat_ff;
   logic        sync1_ff, sync2_ff, line_ff;
   logic [15:0] pre_ff;
   logic        tick_a_ff, tick_b_ff;
   logic [7:0]  bitcnt_ff;
   logic [3:0]  nbit_ff;
   logic [7:0]  shift_ff;
   logic        par_ff;
   rx_state_e   state_ff;
   logic [15:0] nxt_rx_mode, nxt_pair_mode, nxt_setup, nxt_div;
   logic [7:0]  nxt_presc;
   logic        nxt_start, nxt_ack, nxt_ovf, nxt_pef, nxt_fef, nxt_done, nxt_err;
   logic [31:0] nxt_rdat;
   logic [15:0] nxt_pre;
   logic        nxt_tick_a, nxt_tick_b;
   logic [7:0]  nxt_bitcnt;
   logic [3:0]  nxt_nbit;
   logic [7:0]  nxt_shift;
   logic        nxt_par;
   rx_state_e   nxt_state;
   logic        nxt_line;
   // Comb helpers
   logic        wr, rd, rx_line, mck, mid, full_bit, char_done, bad_par, bad_stop;
   logic [7:0]  half_cnt, char_out;
   logic [3:0]  nbits;
   logic        bv, bready;
   logic [7:0]  bdata;

   // Two-entry buffer between the shifter and the data register
   rx_char_buf #(.WIDTH(8)) u_buf (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .in_valid_i (char_done),
      .in_data_i  (char_out),
      .in_ready_o (bready),
      .out_valid_o(bv),
      .out_data_o (bdata),
      .out_ready_i(rd && adr_i == rx_chan_pkg::ADDR_DATA_DIV)
   );

   function automatic logic [7:0] bitrev(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
      begin
         bitrev[i] = v[7-i];
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Bus and register next state
   always_comb
   begin
      wr            = cyc_i && stb_i && we_i && !ack_ff;
      rd            = cyc_i && stb_i && !we_i && !ack_ff;
      nxt_ack       = cyc_i && stb_i && !ack_ff;
      nxt_rx_mode   = rx_mode_ff;
      nxt_pair_mode = pair_mode_ff;
      nxt_setup     = setup_ff;
      nxt_div       = div_ff;
      nxt_presc     = presc_ff;
      nxt_start     = start_ff;
      nxt_rdat      = rdat_ff;
      if (wr && sel_i[1:0] == 2'h3)
      begin
         unique case (adr_i)
            rx_chan_pkg::ADDR_RX_MODE:    nxt_rx_mode   = dat_i[15:0];
            rx_chan_pkg::ADDR_PAIR_MODE:  nxt_pair_mode = dat_i[15:0];
            rx_chan_pkg::ADDR_COMM_SETUP: nxt_setup     = dat_i[15:0];
            rx_chan_pkg::ADDR_DATA_DIV:   nxt_div       = {dat_i[15:8], 8'h00};
            rx_chan_pkg::ADDR_START:      nxt_start     = dat_i[0] && setup_ff[rx_chan_pkg::SETUP_RXE_BIT];
            rx_chan_pkg::ADDR_PRESCALE:   nxt_presc     = dat_i[7:0];
            default:                      nxt_start     = start_ff;
         endcase
      end
      if (!setup_ff[rx_chan_pkg::SETUP_RXE_BIT])
      begin
         nxt_start = 1'b0;
      end
      nxt_rdat = 32'h0;
      if (rd)
      begin
         unique case (adr_i)
            rx_chan_pkg::ADDR_RX_MODE:    nxt_rdat = {16'h0, rx_mode_ff};
            rx_chan_pkg::ADDR_PAIR_MODE:  nxt_rdat = {16'h0, pair_mode_ff};
            rx_chan_pkg::ADDR_COMM_SETUP: nxt_rdat = {16'h0, setup_ff};
            rx_chan_pkg::ADDR_DATA_DIV:   nxt_rdat = {16'h0, div_ff[15:8], bdata};
            rx_chan_pkg::ADDR_STATUS:     nxt_rdat = {25'h0, state_ff != IDLE, bv, 2'h0, fef_ff, pef_ff, ovf_ff};
            rx_chan_pkg::ADDR_START:      nxt_rdat = {31'h0, start_ff};
            rx_chan_pkg::ADDR_PRESCALE:   nxt_rdat = {24'h0, presc_ff};
            default:                      nxt_rdat = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Prescaler, operation clock enable and receiver next state
   always_comb
   begin
      nxt_pre    = pre_ff + 16'h1;
      nxt_tick_a = (pre_ff & ((16'h1 << presc_ff[3:0]) - 16'h1)) == 16'h0;
      nxt_tick_b = (pre_ff & ((16'h1 << presc_ff[7:4]) - 16'h1)) == 16'h0;
      mck        = rx_mode_ff[rx_chan_pkg::MODE_CKS_BIT] ? tick_b_ff : tick_a_ff;
      nxt_line   = sync2_ff;
      rx_line    = line_ff ^ rx_mode_ff[rx_chan_pkg::MODE_SIS_BIT];
      nbits      = setup_ff[rx_chan_pkg::SETUP_DLS_BIT] ? 4'h8 : 4'h7;
      // Bit time 2*(div+1) clocks; div 0 gives clock over two, div 2 clock over six
      full_bit   = mck && bitcnt_ff == {div_ff[15:9], 1'b1};
      half_cnt   = {1'b0, div_ff[15:9]};
      mid        = mck && bitcnt_ff == half_cnt;
      nxt_state  = state_ff;
      nxt_bitcnt = mck ? bitcnt_ff + 8'h1 : bitcnt_ff;
      nxt_nbit   = nbit_ff;
      nxt_shift  = shift_ff;
      nxt_par    = par_ff;
      char_done  = 1'b0;
      bad_par    = 1'b0;
      bad_stop   = 1'b0;
      if (full_bit)
      begin
         nxt_bitcnt = 8'h0;
      end
      unique case (state_ff)
         IDLE:
         begin
            nxt_bitcnt = 8'h0;
            if (start_ff && !rx_line)
            begin
               nxt_state = START;
            end
         end
         START:
         begin
            if (mid)
            begin
               nxt_state = rx_line ? IDLE : DATA;
               nxt_nbit  = 4'h0;
               nxt_par   = 1'b0;
            end
         end
         DATA:
         begin
            if (mid)
            begin
               nxt_shift = {shift_ff[6:0], rx_line};
               nxt_par   = par_ff ^ rx_line;
               nxt_nbit  = nbit_ff + 4'h1;
               if (nbit_ff + 4'h1 == nbits)
               begin
                  nxt_state = setup_ff[rx_chan_pkg::SETUP_PTC_LSB+1 -: 2] == rx_chan_pkg::PAR_NONE ? STOP : PARITY;
               end
            end
         end
         PARITY:
         begin
            if (mid)
            begin
               nxt_par   = par_ff ^ rx_line;
               nxt_state = STOP;
            end
         end
         STOP:
         begin
            if (mid)
            begin
               nxt_state = IDLE;
               char_done = 1'b1;
               bad_stop  = !rx_line;
               unique case (setup_ff[rx_chan_pkg::SETUP_PTC_LSB+1 -: 2])
                  rx_chan_pkg::PAR_EVEN: bad_par = par_ff;
                  rx_chan_pkg::PAR_ODD:  bad_par = !par_ff;
                  default:               bad_par = 1'b0;
               endcase
            end
         end
      endcase
      // Received first in bit 7, or bit 6 with seven bits, after left shifting; align and order
      char_out = nbits == 4'h8 ? shift_ff : {1'b0, shift_ff[6:0]};
      if (setup_ff[rx_chan_pkg::SETUP_DIR_BIT])
      begin
         // Seven-bit mode leaves the top bit clear
         char_out = nbits == 4'h8 ? bitrev(shift_ff) : bitrev({shift_ff[6:0], 1'b0});
      end
      // Flags: set wins over clear by write of one to status
      nxt_ovf  = ovf_ff;
      nxt_pef  = pef_ff;
      nxt_fef  = fef_ff;
      if (wr && sel_i[1:0] == 2'h3 && adr_i == rx_chan_pkg::ADDR_STATUS)
      begin
         nxt_ovf = ovf_ff && !dat_i[rx_chan_pkg::STAT_OVF_BIT];
         nxt_pef = pef_ff && !dat_i[rx_chan_pkg::STAT_PEF_BIT];
         nxt_fef = fef_ff && !dat_i[rx_chan_pkg::STAT_FEF_BIT];
      end
      nxt_ovf  = nxt_ovf || (char_done && !bready);
      nxt_pef  = nxt_pef || bad_par;
      nxt_fef  = nxt_fef || bad_stop;
      nxt_done = char_done;
      nxt_err  = setup_ff[rx_chan_pkg::SETUP_EOC_BIT] && (bad_par || bad_stop || (char_done && !bready));
   end

   ////////////////////////////////////////////////////////////////
   // Registering
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_mode_ff   <= rx_chan_pkg::MODE_RESET;
         pair_mode_ff <= rx_chan_pkg::MODE_RESET;
         setup_ff     <= rx_chan_pkg::SETUP_RESET;
         div_ff       <= rx_chan_pkg::DIV_RESET;
         presc_ff     <= rx_chan_pkg::PRESC_RESET;
         start_ff     <= 1'b0;
         ack_ff       <= 1'b0;
         rdat_ff      <= 32'h0;
         ovf_ff       <= 1'b0;
         pef_ff       <= 1'b0;
         fef_ff       <= 1'b0;
         done_ff      <= 1'b0;
         err_ff       <= 1'b0;
         sync1_ff     <= 1'b1;
         sync2_ff     <= 1'b1;
         line_ff      <= 1'b1;
         pre_ff       <= 16'h0;
         tick_a_ff    <= 1'b0;
         tick_b_ff    <= 1'b0;
         bitcnt_ff    <= 8'h0;
         nbit_ff      <= 4'h0;
         shift_ff     <= 8'h0;
         par_ff       <= 1'b0;
         state_ff     <= IDLE;
      end
      else
      begin
         rx_mode_ff   <= nxt_rx_mode;
         pair_mode_ff <= nxt_pair_mode;
         setup_ff     <= nxt_setup;
         div_ff       <= nxt_div;
         presc_ff     <= nxt_presc;
         start_ff     <= nxt_start;
         ack_ff       <= nxt_ack;
         rdat_ff      <= nxt_rdat;
         ovf_ff       <= nxt_ovf;
         pef_ff       <= nxt_pef;
         fef_ff       <= nxt_fef;
         done_ff      <= nxt_done;
         err_ff       <= nxt_err;
         sync1_ff     <= serial_rx_pin_i;
         sync2_ff     <= sync1_ff;
         line_ff      <= nxt_line;
         pre_ff       <= nxt_pre;
         tick_a_ff    <= nxt_tick_a;
         tick_b_ff    <= nxt_tick_b;
         bitcnt_ff    <= nxt_bitcnt;
         nbit_ff      <= nxt_nbit;
         shift_ff     <= nxt_shift;
         par_ff       <= nxt_par;
         state_ff     <= nxt_state;
      end
   end

   assign dat_o        = rdat_ff;
   assign ack_o        = ack_ff;
   assign rx_done_irq_o  = done_ff;
   assign rx_error_irq_o = err_ff;

   ////////////////////////////////////////////////////////////////
   // Checks
   frame_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_ff == STOP && mid && !rx_line) |=> fef_ff) else $error("stop error not flagged");
   done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_irq_o |=> !rx_done_irq_o) else $error("done not a pulse");
   overrun_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (char_done && !bready) |=> ovf_ff) else $error("overrun missed");
   err_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(setup_ff[rx_chan_pkg::SETUP_EOC_BIT]) |-> !rx_error_irq_o) else $error("error irq unmasked");
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o) else $error("bad ack");
   odd_parity_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_ff == STOP && mid && !par_ff && setup_ff[rx_chan_pkg::SETUP_PTC_LSB+1 -: 2] == rx_chan_pkg::PAR_ODD)
      |=> pef_ff) else $error("odd parity error missed");
endmodule
`default_nettype wire

//--- rtl/rx_chan_pkg.sv
// Package: register map, field layout and constants of the serial receive channel
`default_nettype none
package rx_chan_pkg;
   // Word byte addresses on the register bus
   localparam logic [4:0] ADDR_RX_MODE     = 5'h00;
   localparam logic [4:0] ADDR_PAIR_MODE   = 5'h04;
   localparam logic [4:0] ADDR_COMM_SETUP  = 5'h08;
   localparam logic [4:0] ADDR_DATA_DIV    = 5'h0c;
   localparam logic [4:0] ADDR_STATUS      = 5'h10;
   localparam logic [4:0] ADDR_START       = 5'h14;
   localparam logic [4:0] ADDR_PRESCALE    = 5'h18;
   // Mode register fields
   localparam int MODE_CKS_BIT   = 15;
   localparam int MODE_SIS_BIT   = 6;
   localparam int MODE_MD_BIT    = 0;
   // Setup register fields
   localparam int SETUP_RXE_BIT  = 14;
   localparam int SETUP_EOC_BIT  = 10;
   localparam int SETUP_PTC_LSB  = 8;
   localparam int SETUP_DIR_BIT  = 7;
   localparam int SETUP_SLC_LSB  = 4;
   localparam int SETUP_DLS_BIT  = 0;
   // Status register fields
   localparam int STAT_OVF_BIT   = 0;
   localparam int STAT_PEF_BIT   = 1;
   localparam int STAT_FEF_BIT   = 2;
   localparam int STAT_BUSY_BIT  = 6;
   localparam int STAT_BFF_BIT   = 5;
   // Reset values
   localparam logic [15:0] MODE_RESET  = 16'h0020;
   localparam logic [15:0] SETUP_RESET = 16'h0087;
   localparam logic [15:0] DIV_RESET   = 16'hfe00;
   localparam logic [7:0]  PRESC_RESET = 8'h00;
   // Parity modes
   localparam logic [1:0] PAR_NONE  = 2'h0;
   localparam logic [1:0] PAR_IGN   = 2'h1;
   localparam logic [1:0] PAR_EVEN  = 2'h2;
   localparam logic [1:0] PAR_ODD   = 2'h3;
   // Divider field limits
   localparam logic [6:0] DIV_MIN   = 7'h02;
endpackage
`default_nettype wire

//--- rtl/rx_char_buf.sv
// Two-entry character buffer with valid/ready on both sides
`default_nettype none
module rx_char_buf #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   logic [WIDTH-1:0] mem_ff [2];
   logic [WIDTH-1:0] nxt_mem [2];
   logic [1:0]       cnt_ff;
   logic [1:0]       nxt_cnt;
   logic             push;
   logic             pop;

   always_comb
   begin
      push    = in_valid_i && (cnt_ff != 2'h2);
      pop     = out_ready_i && (cnt_ff != 2'h0);
      nxt_mem = mem_ff;
      nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
      if (pop)
      begin
         nxt_mem[0] = mem_ff[1];
      end
      if (push)
      begin
         nxt_mem[(cnt_ff - 2'(pop)) == 2'h0 ? 0 : 1] = in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_ff    <= 2'h0;
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         mem_ff <= nxt_mem;
      end
   end

   assign in_ready_o  = cnt_ff != 2'h2;
   assign out_valid_o = cnt_ff != 2'h0;
   assign out_data_o  = mem_ff[0];
endmodule
`default_nettype wire

//--- dv/ser_tx_model.sv
// Behavioural remote transmitter that drives the receive line
`default_nettype none
module ser_tx_model (
   // Clock
   input  wire logic clk_i,
   // Serial line
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic inv = 1'b0;

   initial line_o = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // One line level held for n clocks
   task automatic put(input logic b, input int n);
      @(posedge clk_i);
      line_o <= b ^ inv;
      repeat (n - 1) @(posedge clk_i);
   endtask

   // Idle level follows the polarity in use
   task automatic idle(input logic i);
      inv = i;
      @(posedge clk_i);
      line_o <= ~i;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Whole frame; bp flips parity, bs sends a bad stop
   task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input logic lsb,
                       input logic bp, input logic bs, input int n);
      logic b;
      logic p;
      p = (par == 2'h3);
      put(1'b0, n);
      for (int k = 0; k < nb; k++)
      begin
         b = lsb ? d[k] : d[nb - 1 - k];
         p = p ^ b;
         put(b, n);
      end
      if (par != 2'h0)
         put(((par == 2'h1) ? 1'b0 : p) ^ bp, n);
      put(~bs, n);
      if (bs)
         put(1'b1, n);
   endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench of the serial receive channel
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [15:0] setup;
      logic [15:0] mode;
      logic [7:0]  d;
      logic [7:0]  ex;
      logic [2:0]  st;
      logic [2:0]  fl;
   } row_s;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        done_irq;
   logic        err_irq;
   logic        line;
   logic [31:0] rd;
   int          n_errors = 0;
   int          check_count = 0;
   int          n_done = 0;
   int          n_err = 0;
   int          tgt = 0;
   int          e0;
   row_s        r;
   // Flags: {error irq expected, bad stop, bad parity}
   row_s rows[12] = '{
      '{16'h0481, 16'h0020, 8'ha5, 8'ha5, 3'h0, 3'h0}, '{16'h0401, 16'h0020, 8'h3c, 8'h3c, 3'h0, 3'h0},
      '{16'h0581, 16'h0020, 8'h96, 8'h96, 3'h0, 3'h1}, '{16'h0681, 16'h0020, 8'h07, 8'h07, 3'h0, 3'h0},
      '{16'h0781, 16'h0020, 8'he1, 8'he1, 3'h0, 3'h0}, '{16'h0601, 16'h0020, 8'h5b, 8'h5b, 3'h2, 3'h5},
      '{16'h0280, 16'h0020, 8'hff, 8'h7f, 3'h2, 3'h1}, '{16'h0400, 16'h0020, 8'hc5, 8'h45, 3'h0, 3'h0},
      '{16'h0481, 16'h0020, 8'ha5, 8'ha5, 3'h4, 3'h6}, '{16'h0481, 16'h0060, 8'h5a, 8'h5a, 3'h0, 3'h0},
      '{16'h0781, 16'h0060, 8'h3e, 8'h3e, 3'h2, 3'h5}, '{16'h0481, 16'h8020, 8'h81, 8'h81, 3'h0, 3'h0}};
   logic [4:0]  ra[8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c};
   logic [15:0] rv[8] = '{16'h0020, 16'h0020, 16'h0087, 16'hfe00, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   always #5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      if (done_irq === 1'b1)
         n_done <= n_done + 1;
      if (err_irq === 1'b1)
         n_err <= n_err + 1;
   end

   async_serial_receiver_channel async_serial_receiver_channel_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .serial_rx_pin_i(line), .rx_done_irq_o(done_irq),
      .rx_error_irq_o(err_irq));

   ser_tx_model ser_tx_model_i (.clk_i(clk_i), .line_o(line));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Classic single cycle, held until ack
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack_o !== 1'b1 && k < 20);
      `CHK(ack_o, 1'b1)
      if (ack_o !== 1'b1)
         conclude();
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wait_done();
      tgt++;
      for (int k = 0; k < 400 && n_done < tgt; k++)
         @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      `CHK(n_done, tgt)
      if (n_done < tgt)
         conclude();
   endtask

   // Stop, set both modes and polarity, enable, then start
   task automatic cfg(input logic [15:0] s, input logic [15:0] m);
      wb(1'b0 ^ 1'b1, rx_chan_pkg::ADDR_COMM_SETUP, 32'h0);
      wb(1'b1, rx_chan_pkg::ADDR_RX_MODE, {16'h0, m});
      wb(1'b1, rx_chan_pkg::ADDR_PAIR_MODE, {16'h0, m & 16'h8020});
      ser_tx_model_i.idle(m[6]);
      wb(1'b1, rx_chan_pkg::ADDR_COMM_SETUP, {16'h0, s | 16'h4000});
      repeat (4) @(posedge clk_i);
      wb(1'b1, rx_chan_pkg::ADDR_START, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         wb(1'b0, ra[i], 32'h0);
         `CHK(rd, {16'h0, rv[i]})
      end
      $display("reset values done");
      wb(1'b1, rx_chan_pkg::ADDR_DATA_DIV, 32'h0400);
      wb(1'b1, rx_chan_pkg::ADDR_PRESCALE, 32'h10);
      for (int i = 0; i < 12; i++)
      begin
         r = rows[i];
         cfg(r.setup, r.mode);
         e0 = n_err;
         ser_tx_model_i.send(r.d, r.setup[0] ? 8 : 7, r.setup[9:8], r.setup[7], r.fl[0], r.fl[1],
                             6 << r.mode[15]);
         wait_done();
         `CHK(n_err != e0, r.fl[2])
         wb(1'b0, rx_chan_pkg::ADDR_DATA_DIV, 32'h0);
         `CHK(rd[15:0], 16'h0400 | {8'h00, r.ex})
         wb(1'b0, rx_chan_pkg::ADDR_STATUS, 32'h0);
         `CHK(rd[2:0], r.st)
         wb(1'b1, rx_chan_pkg::ADDR_STATUS, 32'h7);
         $display("row %0d done", i);
      end
      // Three characters into a two-entry buffer
      cfg(16'h0481, 16'h0020);
      e0 = n_err;
      for (int k = 1; k < 4; k++)
      begin
         ser_tx_model_i.send(8'h11 * k[7:0], 8, 2'h0, 1'b1, 1'b0, 1'b0, 6);
         wait_done();
      end
      `CHK(n_err != e0, 1'b1)
      wb(1'b0, rx_chan_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[0], 1'b1)
      wb(1'b0, rx_chan_pkg::ADDR_DATA_DIV, 32'h0);
      `CHK(rd[7:0], 8'h11)
      wb(1'b0, rx_chan_pkg::ADDR_DATA_DIV, 32'h0);
      `CHK(rd[7:0], 8'h22)
      wb(1'b1, rx_chan_pkg::ADDR_STATUS, 32'h7);
      wb(1'b0, rx_chan_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[5:0], 6'h00)
      $display("overrun done");
      // Narrow byte select leaves the register as it was
      sel <= 4'hc;
      wb(1'b1, rx_chan_pkg::ADDR_PRESCALE, 32'h55);
      sel <= 4'hf;
      wb(1'b0, rx_chan_pkg::ADDR_PRESCALE, 32'h0);
      `CHK(rd[7:0], 8'h10)
      $display("byte select done");
      conclude();
   end
endmodule
`default_nettype wire
